// ==== tb/cmq_ctl_model.sv ====
// Protocol controller model: takes frames with a set delay
`timescale 1ns/100ps

module cmq_ctl_model (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        sys_rst,
  // Frame from block
  input  wire        tx_req,
  input  wire [28:0] tx_frame_identifier,
  // Behaviour
  input  wire        stall,
  input  wire [3:0]  ack_dly,
  // Answers
  output reg         ctl_tx_ack,
  output reg         ctl_tx_done,
  output wire        ctl_tx_busy,
  output reg  [7:0]  n_sent
);
  reg [28:0] sent_id [0:15];
  reg [3:0]  wait_q;
  reg        busy_q;
  assign ctl_tx_busy = stall | busy_q;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_tx_ack <= 1'b0;
      ctl_tx_done <= 1'b0;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      n_sent <= 8'h00;
    end else begin
      ctl_tx_ack <= 1'b0;
      ctl_tx_done <= busy_q;
      busy_q <= 1'b0;
      if (tx_req && !ctl_tx_ack && !busy_q) begin
        if (wait_q == ack_dly) begin
          ctl_tx_ack <= 1'b1;
          busy_q <= 1'b1;
          wait_q <= 4'h0;
          sent_id[n_sent[3:0]] <= tx_frame_identifier;
          n_sent <= n_sent + 8'h01;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

// ==== tb/cmq_props.sv ====
// Concurrent checks on the CAN queue top ports
`timescale 1ns/100ps
`include "cmq_defs.vh"

module cmq_props (
  // Clock and reset
  input wire        ref_clk,
  input wire        sys_rst,
  // Register bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Controller side
  input wire        ctl_bus_off,
  input wire        ctl_error,
  input wire        ctl_tx_busy,
  input wire        ctl_rx_busy,
  input wire        ctl_rx_avail,
  input wire        ctl_tx_ack,
  input wire        controller_active,
  input wire        tx_req,
  input wire [28:0] tx_frame_identifier,
  input wire [3:0]  tx_payload_length,
  input wire [63:0] tx_data
);
  // ==========
  // Checks
  wire [4:0] lvl = {ctl_bus_off, ctl_error, ctl_tx_busy, ctl_rx_busy, ctl_rx_avail};
  wire       rd_st = wb_ack_o && !wb_we_i && wb_adr_i == `CMQ_REG_STATUS;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  bus_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  status_level_a:
    assert property (rd_st && $past(lvl, 1) == $past(lvl, 2) && $past(lvl, 2) == $past(lvl, 3)
      |-> {wb_dat_o[7:4], wb_dat_o[0]} == $past(lvl, 2))
    else $error("status level");
  status_free_a:
    assert property (rd_st && $past(tx_req, 1) == $past(tx_req, 2)
      && $past(tx_req, 2) == $past(tx_req, 3) |-> wb_dat_o[2] == !$past(tx_req, 2))
    else $error("status bit 2");
  req_hold_a:
    assert property (tx_req && !ctl_tx_ack |=> tx_req || !controller_active)
    else $error("request dropped");
  req_drop_a:
    assert property (tx_req && ctl_tx_ack |=> !tx_req)
    else $error("request kept");
  frame_steady_a:
    assert property (tx_req ##1 tx_req |-> $stable(tx_frame_identifier) && $stable(tx_data)
      && $stable(tx_payload_length))
    else $error("frame moved");
  len_limit_a:
    assert property (tx_req |-> tx_payload_length <= 4'h8)
    else $error("length over 8");
  off_quiet_a:
    assert property (!controller_active ##1 !controller_active |-> !tx_req)
    else $error("request while off");
  cover property (rd_st);
  cover property (tx_req && ctl_tx_ack);
  cover property ($fell(controller_active));
endmodule

bind cmq_top cmq_props i_cmq_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ctl_bus_off(ctl_bus_off), .ctl_error(ctl_error), .ctl_tx_busy(ctl_tx_busy),
  .ctl_rx_busy(ctl_rx_busy), .ctl_rx_avail(ctl_rx_avail), .ctl_tx_ack(ctl_tx_ack),
  .controller_active(controller_active), .tx_req(tx_req),
  .tx_frame_identifier(tx_frame_identifier), .tx_payload_length(tx_payload_length),
  .tx_data(tx_data));

// ==== tb/test_cmq_top.sv ====
// Self-checking bench for the CAN queue top
`timescale 1ns/100ps
`include "cmq_defs.vh"

module test_cmq_top;
  reg ref_clk, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg ovr = 0, stall = 0, rx_valid = 0;
  reg [7:0] wb_adr_i = 0;
  reg [31:0] wb_dat_i = 0, cyc, t;
  reg [3:0] lvl = 0, ack_dly = 2;
  reg [28:0] rx_id = 0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, tx_busy, tx_ack, tx_done, controller_active, tx_req, tx_ext, tx_rtr;
  wire [28:0] tx_id;
  wire [3:0] tx_len;
  wire [63:0] tx_data;
  wire [7:0] n_sent;
  integer miscompares = 0;
  integer n_checks = 0;

  cmq_top i_cmq_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctl_bus_off(lvl[3]),
    .ctl_error(lvl[2]), .ctl_tx_busy(tx_busy), .ctl_rx_busy(lvl[1]), .ctl_overrun(ovr),
    .ctl_rx_avail(lvl[0]), .controller_active(controller_active), .bit_timing_lo(),
    .bit_timing_hi(), .tx_req(tx_req), .tx_ext(tx_ext), .tx_frame_identifier(tx_id),
    .tx_rtr(tx_rtr), .tx_payload_length(tx_len), .tx_data(tx_data), .ctl_tx_ack(tx_ack),
    .ctl_tx_done(tx_done), .ctl_rx_valid(rx_valid), .rx_ext(1'b1), .rx_frame_identifier(rx_id),
    .rx_rtr(1'b1), .rx_payload_length(4'h3), .rx_data({35'h0, rx_id}));
  cmq_ctl_model i_cmq_ctl_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .tx_req(tx_req),
    .tx_frame_identifier(tx_id), .stall(stall), .ack_dly(ack_dly), .ctl_tx_ack(tx_ack),
    .ctl_tx_done(tx_done), .ctl_tx_busy(tx_busy), .n_sent(n_sent));

  // ==========
  // Helpers
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= sys_rst ? 32'h0 : cyc + 32'h1;
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wb(input we, input [7:0] a, input [31:0] d, output [31:0] r);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge ref_clk);
      while (wb_ack_o !== 1'b1) @(posedge ref_clk);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] x;
    wb(1'b1, a, d, x);
  endtask
  task rdm(input [7:0] a, input [31:0] m, input [31:0] e);
    reg [31:0] x;
    begin
      wb(1'b0, a, 32'h0, x);
      chk(x & m, e);
    end
  endtask
  task cmd(input integer b);
    wr(`CMQ_REG_CTRL, 32'h1 << b);
  endtask
  task rx(input [28:0] id);
    begin
      rx_valid <= 1'b1;
      rx_id <= id;
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task print_verdict;
    begin
      if (miscompares == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // ==========
  // Scenarios
  task t_reset_status;
    begin
      rdm(`CMQ_REG_STATUS, 32'hFF, 32'h04);
      rdm(`CMQ_REG_RESULT, 32'h1FFF, 32'h1000);
      rdm(`CMQ_REG_ACC_MASK, 32'hFFFFFFFF, `CMQ_RST_ACC_MASK);
      rdm(8'hF0, 32'hFFFFFFFF, 32'h0);
      lvl <= 4'hF;
      stall <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdm(`CMQ_REG_STATUS, 32'hFF, 32'hF5);
      lvl <= 4'h0;
      stall <= 1'b0;
      ovr <= 1'b1;
      @(posedge ref_clk);
      ovr <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rdm(`CMQ_REG_STATUS, 32'hFF, 32'h06);
      cmd(`CMQ_CMD_CLR_OVR);
      rdm(`CMQ_REG_STATUS, 32'hFF, 32'h04);
    end
  endtask
  task t_tx;
    begin
      wr(`CMQ_REG_ACC_CODE, 32'h123);
      wr(`CMQ_REG_ACC_MASK, 32'hFFFFF000);
      cmd(`CMQ_CMD_ACTIVATE);
      stall <= 1'b1;
      wr(`CMQ_REG_TX_ID, 32'h4ABCDEF0);
      wr(`CMQ_REG_TX_LEN, 32'h9);
      wr(`CMQ_REG_TX_DLO, 32'h33221100);
      wr(`CMQ_REG_TX_DHI, 32'h77665544);
      repeat (4) cmd(`CMQ_CMD_TX_PUSH);
      rdm(`CMQ_REG_RESULT, 32'h1, 32'h0);
      cmd(`CMQ_CMD_TX_PUSH);
      rdm(`CMQ_REG_RESULT, 32'h1, 32'h1);
      cmd(`CMQ_CMD_FLUSH_TX);
      cmd(`CMQ_CMD_TX_PUSH);
      rdm(`CMQ_REG_RESULT, 32'h1, 32'h0);
      stall <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({tx_req, tx_ext, tx_rtr, tx_id, tx_len}, {3'b110, 29'h0ABCDEF0, 4'h8});
      chk(tx_data, 64'h7766554433221100);
      repeat (20) @(posedge ref_clk);
      chk(n_sent, 8'h1);
      rdm(`CMQ_REG_STATUS, 32'h8, 32'h8);
    end
  endtask
  task t_rx;
    begin
      while (cyc % 1000 != 500) @(posedge ref_clk);
      t = cyc / 1000;
      rx(29'h1000123);
      rx(29'h124);
      rdm(`CMQ_REG_RESULT, 32'h1700, 32'h0100);
      rdm(`CMQ_REG_RX_ID, 32'h7FFFFFFF, 32'h61000123);
      rdm(`CMQ_REG_RX_LEN, 32'hF, 32'h3);
      rdm(`CMQ_REG_RX_DLO, 32'hFFFFFFFF, 32'h01000123);
      rdm(`CMQ_REG_STAMP_HI, 32'hFFFFFFFF, 32'h0);
      rdm(`CMQ_REG_STAMP_LO, 32'hFFFFFFFF, t);
      cmd(`CMQ_CMD_RX_POP);
      rdm(`CMQ_REG_RESULT, 32'h1700, 32'h1000);
      repeat (5) rx(29'h123);
      rdm(`CMQ_REG_RESULT, 32'h0708, 32'h0408);
      cmd(`CMQ_CMD_FLUSH_RX);
      rdm(`CMQ_REG_RESULT, 32'h1708, 32'h1000);
      cmd(`CMQ_CMD_DEACT);
      rx(29'h123);
      rdm(`CMQ_REG_RESULT, 32'h0700, 32'h0);
    end
  endtask
  task t_cyc;
    integer i;
    reg [7:0] n0;
    begin
      cmd(`CMQ_CMD_ACTIVATE);
      stall <= 1'b1;
      wr(`CMQ_REG_CYC_PER, 32'h4);
      cmd(`CMQ_CMD_CYC_ADD);
      rdm(`CMQ_REG_RESULT, 32'h2, 32'h2);
      for (i = 0; i < 5; i = i + 1) begin
        wr(`CMQ_REG_TX_ID, i + 1);
        wr(`CMQ_REG_CYC_PER, 32'h5);
        cmd(`CMQ_CMD_CYC_ADD);
        rdm(`CMQ_REG_RESULT, 32'h72, i << 4);
      end
      cmd(`CMQ_CMD_CYC_ADD);
      rdm(`CMQ_REG_RESULT, 32'h2, 32'h2);
      wr(`CMQ_REG_CYC_HDL, 32'h4);
      cmd(`CMQ_CMD_CYC_DEL);
      rdm(`CMQ_REG_RESULT, 32'h4, 32'h0);
      cmd(`CMQ_CMD_CYC_EN);
      rdm(`CMQ_REG_RESULT, 32'h4, 32'h4);
      wr(`CMQ_REG_CYC_HDL, 32'h1);
      cmd(`CMQ_CMD_CYC_EN);
      wr(`CMQ_REG_CYC_HDL, 32'h0);
      cmd(`CMQ_CMD_CYC_EN);
      repeat (5200) @(posedge ref_clk);
      n0 = n_sent;
      stall <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk(i_cmq_ctl_model.sent_id[n0[3:0]], 29'h1);
      chk(i_cmq_ctl_model.sent_id[n0[3:0] + 4'h1], 29'h2);
      repeat (7470) @(posedge ref_clk);
      chk(n_sent - n0, 8'h4);
      ack_dly <= 4'hF;
      while (tx_req !== 1'b1) @(posedge ref_clk);
      cmd(`CMQ_CMD_DEACT);
      chk(tx_req, 1'b0);
    end
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    @(posedge ref_clk);
    t_reset_status;
    t_tx;
    t_rx;
    t_cyc;
    print_verdict;
  end
  initial begin
    #4000000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule

// ==== verilog/cmq_defs.vh ====
// Constants for the CAN message queue block
`ifndef CMQ_DEFS_VH
`define CMQ_DEFS_VH

// ==========
// Register byte offsets
`define CMQ_REG_CTRL      8'h00
`define CMQ_REG_STATUS    8'h04
`define CMQ_REG_RESULT    8'h08
`define CMQ_REG_ACC_CODE  8'h0C
`define CMQ_REG_ACC_MASK  8'h10
`define CMQ_REG_TIMING    8'h14
`define CMQ_REG_TX_ID     8'h18
`define CMQ_REG_TX_LEN    8'h1C
`define CMQ_REG_TX_DLO    8'h20
`define CMQ_REG_TX_DHI    8'h24
`define CMQ_REG_CYC_PER   8'h28
`define CMQ_REG_CYC_HDL   8'h2C
`define CMQ_REG_RX_ID     8'h30
`define CMQ_REG_RX_LEN    8'h34
`define CMQ_REG_RX_DLO    8'h38
`define CMQ_REG_RX_DHI    8'h3C
`define CMQ_REG_STAMP_HI  8'h40
`define CMQ_REG_STAMP_LO  8'h44

// ==========
// Command bits in the control register
`define CMQ_CMD_ACTIVATE  0
`define CMQ_CMD_DEACT     1
`define CMQ_CMD_CLR_OVR   2
`define CMQ_CMD_FLUSH_TX  3
`define CMQ_CMD_FLUSH_RX  4
`define CMQ_CMD_TX_PUSH   5
`define CMQ_CMD_RX_POP    6
`define CMQ_CMD_CYC_ADD   7
`define CMQ_CMD_CYC_DEL   8
`define CMQ_CMD_CYC_EN    9
`define CMQ_CMD_CYC_DIS   10
`define CMQ_CMD_CYC_RST   11

// ==========
// Frame layout: {ext, id[28:0], rtr, len[3:0], data[63:0]}
`define CMQ_FRM_W         99
`define CMQ_FRM_EXT       98
`define CMQ_FRM_ID_HI     97
`define CMQ_FRM_ID_LO     69
`define CMQ_FRM_RTR       68
`define CMQ_FRM_LEN_HI    67
`define CMQ_FRM_LEN_LO    64
`define CMQ_MAX_LEN       4'h8

// ==========
// Sizes, reset values and timing
`define CMQ_QDEPTH        4
`define CMQ_QCNT_FULL     3'h4
`define CMQ_SLOTS         5
`define CMQ_MIN_PERIOD    16'h0005
`define CMQ_CLK_NS        100
`define CMQ_TICK_NS       100000
`define CMQ_TICK_CYC      (`CMQ_TICK_NS / `CMQ_CLK_NS)
`define CMQ_RST_TIMING    8'h00
`define CMQ_RST_ACC_CODE  32'h0000_0000
`define CMQ_RST_ACC_MASK  32'hFFFF_FFFF

`endif

// ==== verilog/cmq_prio.v ====
// Lowest-index-first picker over five slot requests
`timescale 1ns/100ps

module cmq_prio (
  // Requests
  input  wire [4:0] req,
  // Result
  output reg        any,
  output reg  [2:0] idx
);

  integer i;

  always @* begin
    any = 1'b0;
    idx = 3'h0;
    for (i = 4; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[2:0];
      end
    end
  end

endmodule

// ==== verilog/cmq_stamp.v ====
// Receive timestamp counter in 0.1 ms units
`timescale 1ns/100ps
`include "cmq_defs.vh"

module cmq_stamp (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        sys_rst,
  // Time base
  output reg         tick_q,
  output reg  [63:0] stamp_q
);

  reg [15:0] pre_q;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q   <= 16'h0000;
      tick_q  <= 1'b0;
      stamp_q <= 64'h0;
    end else if (pre_q == `CMQ_TICK_CYC - 1) begin
      pre_q   <= 16'h0000;
      tick_q  <= 1'b1;
      stamp_q <= stamp_q + 64'h1;
    end else begin
      pre_q  <= pre_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

endmodule

// ==== verilog/cmq_top.v ====
// CAN message queue front end with cyclic transmit engine
// Summary of operation
// - Status bit 7 shows bus-off, 1 while off, 0 while on.
// - Status bit 6 is 1 while any error condition is present.
// - Status bit 5 shows transmitting, bit 4 shows receiving.
// - Bit 3 shows last transmission complete; bit 2 shows buffer released.
// - Status bit 1 sets on hardware receive buffer overrun.
// - Status bit 0 shows a message waiting in hardware receive buffer.
// - Clear-overrun command resets the overrun indication.
// - Requests carry format flag, identifier, remote flag, length up to 8.
// - Requests queue and go out when bus idle; full queue refuses.
// - Flush command empties transmit queue and clears full.
// - Every received frame gets a 64-bit stamp in 0.1 ms units.
// - Received frames deliver format, identifier, remote flag, length, data.
// - Receive-queue-full stays flagged until receive flush.
// - Receive count readable anytime; receive flush zeroes it.
// - Up to five cyclic slots; add stores frame, period, returns handle.
// - Among due cyclic entries the lowest handle goes first.
// - Add refused with config error when full or period below 5.
// - Delete or enable with unknown handle gives handle error.
// - Enabled cyclic entry transmits once per elapsed period.
// - Deactivate stops transmit, receive and controller interrupts.
// - Identifier admitted when all unmasked bits match the code.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "cmq_defs.vh"

module cmq_top (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        sys_rst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Protocol controller status
  input  wire        ctl_bus_off,
  input  wire        ctl_error,
  input  wire        ctl_tx_busy,
  input  wire        ctl_rx_busy,
  input  wire        ctl_overrun,
  input  wire        ctl_rx_avail,
  // Protocol controller set-up
  output reg         controller_active,
  output reg  [7:0]  bit_timing_lo,
  output reg  [7:0]  bit_timing_hi,
  // Transmit frame towards controller
  output reg         tx_req,
  output reg         tx_ext,
  output reg  [28:0] tx_frame_identifier,
  output reg         tx_rtr,
  output reg  [3:0]  tx_payload_length,
  output reg  [63:0] tx_data,
  input  wire        ctl_tx_ack,
  input  wire        ctl_tx_done,
  // Received frame from controller
  input  wire        ctl_rx_valid,
  input  wire        rx_ext,
  input  wire [28:0] rx_frame_identifier,
  input  wire        rx_rtr,
  input  wire [3:0]  rx_payload_length,
  input  wire [63:0] rx_data
);

  // ==========
  // Register state
  reg [31:0] accept_code_q;
  reg [31:0] accept_mask_q;
  reg [30:0] stg_id_q;
  reg [3:0]  stg_len_q;
  reg [63:0] stg_dlo_hi_q;
  reg [15:0] cyclic_period_q;
  reg [2:0]  cyc_hdl_q;
  reg [2:0]  last_hdl_q;
  reg        tx_full_q;
  reg        cfg_err_q;
  reg        hdl_err_q;
  reg        rx_qfull_q;
  reg        overrun_q;
  reg        tx_done_q;
  reg [7:0]  status_q;
  reg [31:0] rd_d;

  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr_ok  = wb_req & wb_we_i;
  wire [11:0] cmd    = (wr_ok && wb_adr_i == `CMQ_REG_CTRL) ? wb_dat_i[11:0] : 12'h000;
  wire        flush_tx_queue = cmd[`CMQ_CMD_FLUSH_TX];
  wire        flush_rx_queue = cmd[`CMQ_CMD_FLUSH_RX];
  wire        clear_overrun  = cmd[`CMQ_CMD_CLR_OVR];

  // ==========
  // Time base and staged frame
  wire        tick;
  wire [63:0] stamp;

  cmq_stamp u_stamp (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tick_q  (tick),
    .stamp_q (stamp)
  );

  // Length above 8 is clamped
  wire [3:0] stg_len = (stg_len_q > `CMQ_MAX_LEN) ? `CMQ_MAX_LEN : stg_len_q;
  wire [`CMQ_FRM_W-1:0] stg_frm = {stg_id_q[30], stg_id_q[28:0], stg_id_q[29],
                                   stg_len, stg_dlo_hi_q};

  // ==========
  // Cyclic slots
  reg  [4:0]            slot_used_q;
  reg  [4:0]            slot_en_q;
  reg  [4:0]            slot_due_q;
  reg  [15:0]           slot_per_q [0:4];
  reg  [15:0]           slot_cnt_q [0:4];
  reg  [`CMQ_FRM_W-1:0] slot_frm_q [0:4];

  wire       free_any;
  wire [2:0] free_idx;
  wire       due_any;
  wire [2:0] due_idx;

  cmq_prio u_free (
    .req (~slot_used_q),
    .any (free_any),
    .idx (free_idx)
  );

  cmq_prio u_due (
    .req (slot_due_q),
    .any (due_any),
    .idx (due_idx)
  );

  wire hdl_ok  = (cyc_hdl_q < 3'h5) && slot_used_q[cyc_hdl_q];
  wire cyc_add = cmd[`CMQ_CMD_CYC_ADD];
  wire add_ok  = cyc_add & free_any & (cyclic_period_q >= `CMQ_MIN_PERIOD);
  wire hdl_cmd = cmd[`CMQ_CMD_CYC_DEL] | cmd[`CMQ_CMD_CYC_EN] | cmd[`CMQ_CMD_CYC_DIS];

  // ==========
  // Transmit queue
  reg [`CMQ_FRM_W-1:0] txq_q [0:`CMQ_QDEPTH-1];
  reg [1:0]            txq_wp_q;
  reg [1:0]            txq_rp_q;
  reg [2:0]            txq_cnt_q;

  wire txq_full = (txq_cnt_q == `CMQ_QCNT_FULL);
  wire tx_push  = cmd[`CMQ_CMD_TX_PUSH] & ~txq_full & ~flush_tx_queue;
  wire tx_start = controller_active & ~tx_req & ~ctl_tx_busy & ~flush_tx_queue &
                  (due_any | (txq_cnt_q != 3'h0));
  wire take_cyc = tx_start & due_any;
  wire take_q   = tx_start & ~due_any;
  wire [`CMQ_FRM_W-1:0] start_frm = due_any ? slot_frm_q[due_idx] : txq_q[txq_rp_q];

  genvar g;
  generate
    for (g = 0; g < `CMQ_SLOTS; g = g + 1) begin : g_slot
      wire hit = (cyc_hdl_q == g) & hdl_ok;
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          slot_used_q[g] <= 1'b0;
          slot_en_q[g]   <= 1'b0;
          slot_due_q[g]  <= 1'b0;
          slot_per_q[g]  <= 16'h0000;
          slot_cnt_q[g]  <= 16'h0000;
          slot_frm_q[g]  <= {`CMQ_FRM_W{1'b0}};
        end else if (cmd[`CMQ_CMD_CYC_RST] | (cmd[`CMQ_CMD_CYC_DEL] & hit)) begin
          slot_used_q[g] <= 1'b0;
          slot_en_q[g]   <= 1'b0;
          slot_due_q[g]  <= 1'b0;
        end else if (add_ok && free_idx == g) begin
          slot_used_q[g] <= 1'b1;
          slot_en_q[g]   <= 1'b0;
          slot_due_q[g]  <= 1'b0;
          slot_per_q[g]  <= cyclic_period_q;
          slot_cnt_q[g]  <= cyclic_period_q;
          slot_frm_q[g]  <= stg_frm;
        end else begin
          if (cmd[`CMQ_CMD_CYC_EN] & hit) begin
            slot_en_q[g]  <= 1'b1;
            slot_cnt_q[g] <= slot_per_q[g];
          end else if (cmd[`CMQ_CMD_CYC_DIS] & hit) begin
            slot_en_q[g] <= 1'b0;
          end else if (slot_en_q[g] & tick) begin
            if (slot_cnt_q[g] <= 16'h0001) begin
              slot_cnt_q[g] <= slot_per_q[g];
            end else begin
              slot_cnt_q[g] <= slot_cnt_q[g] - 16'h0001;
            end
          end
          // New due event wins over the take
          if (slot_en_q[g] & tick & (slot_cnt_q[g] <= 16'h0001)) begin
            slot_due_q[g] <= 1'b1;
          end else if (~slot_en_q[g] | (take_cyc && due_idx == g)) begin
            slot_due_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========
  // Transmit queue and request
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txq_wp_q            <= 2'h0;
      txq_rp_q            <= 2'h0;
      txq_cnt_q           <= 3'h0;
      tx_req              <= 1'b0;
      tx_ext              <= 1'b0;
      tx_frame_identifier <= 29'h0;
      tx_rtr              <= 1'b0;
      tx_payload_length   <= 4'h0;
      tx_data             <= 64'h0;
    end else begin
      if (flush_tx_queue) begin
        txq_wp_q  <= 2'h0;
        txq_rp_q  <= 2'h0;
        txq_cnt_q <= 3'h0;
      end else begin
        if (tx_push) begin
          txq_q[txq_wp_q] <= stg_frm;
          txq_wp_q        <= txq_wp_q + 2'h1;
        end
        if (take_q) begin
          txq_rp_q <= txq_rp_q + 2'h1;
        end
        txq_cnt_q <= txq_cnt_q + {2'h0, tx_push} - {2'h0, take_q};
      end
      if (tx_start) begin
        tx_req              <= 1'b1;
        tx_ext              <= start_frm[`CMQ_FRM_EXT];
        tx_frame_identifier <= start_frm[`CMQ_FRM_ID_HI:`CMQ_FRM_ID_LO];
        tx_rtr              <= start_frm[`CMQ_FRM_RTR];
        tx_payload_length   <= start_frm[`CMQ_FRM_LEN_HI:`CMQ_FRM_LEN_LO];
        tx_data             <= start_frm[63:0];
      end else if (ctl_tx_ack | ~controller_active) begin
        tx_req <= 1'b0;
      end
    end
  end

  // ==========
  // Receive filter and queue
  reg [`CMQ_FRM_W-1:0] rxq_q   [0:`CMQ_QDEPTH-1];
  reg [63:0]           rxq_ts_q [0:`CMQ_QDEPTH-1];
  reg [1:0]            rxq_wp_q;
  reg [1:0]            rxq_rp_q;
  reg [2:0]            rxq_cnt_q;

  wire rx_match = (((rx_frame_identifier ^ accept_code_q[28:0]) &
                    ~accept_mask_q[28:0]) == 29'h0);
  wire rx_in    = ctl_rx_valid & controller_active & rx_match & ~flush_rx_queue;
  wire rx_push  = rx_in & (rxq_cnt_q != `CMQ_QCNT_FULL);
  wire rx_pop   = cmd[`CMQ_CMD_RX_POP] & (rxq_cnt_q != 3'h0) & ~flush_rx_queue;
  wire [`CMQ_FRM_W-1:0] rx_head = rxq_q[rxq_rp_q];
  wire [63:0]           ts_head = rxq_ts_q[rxq_rp_q];

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxq_wp_q   <= 2'h0;
      rxq_rp_q   <= 2'h0;
      rxq_cnt_q  <= 3'h0;
      rx_qfull_q <= 1'b0;
    end else begin
      if (flush_rx_queue) begin
        rxq_wp_q  <= 2'h0;
        rxq_rp_q  <= 2'h0;
        rxq_cnt_q <= 3'h0;
      end else begin
        if (rx_push) begin
          rxq_q[rxq_wp_q]    <= {rx_ext, rx_frame_identifier, rx_rtr,
                                 rx_payload_length, rx_data};
          rxq_ts_q[rxq_wp_q] <= stamp;
          rxq_wp_q           <= rxq_wp_q + 2'h1;
        end
        if (rx_pop) begin
          rxq_rp_q <= rxq_rp_q + 2'h1;
        end
        rxq_cnt_q <= rxq_cnt_q + {2'h0, rx_push} - {2'h0, rx_pop};
      end
      // Flush wins: a frame arriving in the flush cycle is dropped unflagged
      if (rx_in & ~rx_push) begin
        rx_qfull_q <= 1'b1;
      end else if (flush_rx_queue) begin
        rx_qfull_q <= 1'b0;
      end
    end
  end

  // ==========
  // Control, flags and controller status
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      controller_active <= 1'b0;
      bit_timing_lo     <= `CMQ_RST_TIMING;
      bit_timing_hi     <= 8'h00;
      accept_code_q     <= `CMQ_RST_ACC_CODE;
      accept_mask_q     <= `CMQ_RST_ACC_MASK;
      stg_id_q          <= 31'h0;
      stg_len_q         <= 4'h0;
      stg_dlo_hi_q      <= 64'h0;
      cyclic_period_q   <= 16'h0000;
      cyc_hdl_q         <= 3'h0;
      last_hdl_q        <= 3'h0;
      tx_full_q         <= 1'b0;
      cfg_err_q         <= 1'b0;
      hdl_err_q         <= 1'b0;
      overrun_q         <= 1'b0;
      tx_done_q         <= 1'b0;
      status_q          <= 8'h00;
    end else begin
      if (cmd[`CMQ_CMD_DEACT]) begin
        controller_active <= 1'b0;
      end else if (cmd[`CMQ_CMD_ACTIVATE]) begin
        controller_active <= 1'b1;
      end
      if (wr_ok) begin
        case (wb_adr_i)
          `CMQ_REG_ACC_CODE: accept_code_q <= wb_dat_i;
          `CMQ_REG_ACC_MASK: accept_mask_q <= wb_dat_i;
          `CMQ_REG_TIMING: begin
            bit_timing_lo <= wb_dat_i[7:0];
            bit_timing_hi <= wb_dat_i[15:8];
          end
          `CMQ_REG_TX_ID:   stg_id_q              <= wb_dat_i[30:0];
          `CMQ_REG_TX_LEN:  stg_len_q             <= wb_dat_i[3:0];
          `CMQ_REG_TX_DLO:  stg_dlo_hi_q[31:0]    <= wb_dat_i;
          `CMQ_REG_TX_DHI:  stg_dlo_hi_q[63:32]   <= wb_dat_i;
          `CMQ_REG_CYC_PER: cyclic_period_q       <= wb_dat_i[15:0];
          `CMQ_REG_CYC_HDL: cyc_hdl_q             <= wb_dat_i[2:0];
          default: ;
        endcase
      end
      // Result flags reflect the latest command of their kind
      if (cmd[`CMQ_CMD_TX_PUSH] | flush_tx_queue) begin
        tx_full_q <= cmd[`CMQ_CMD_TX_PUSH] & txq_full & ~flush_tx_queue;
      end
      if (cyc_add) begin
        cfg_err_q <= ~add_ok;
      end
      if (add_ok) begin
        last_hdl_q <= free_idx;
      end
      if (hdl_cmd) begin
        hdl_err_q <= ~hdl_ok;
      end
      // Overrun event wins over the clear
      if (ctl_overrun) begin
        overrun_q <= 1'b1;
      end else if (clear_overrun) begin
        overrun_q <= 1'b0;
      end
      if (ctl_tx_done) begin
        tx_done_q <= 1'b1;
      end else if (tx_start) begin
        tx_done_q <= 1'b0;
      end
      status_q <= {ctl_bus_off, ctl_error, ctl_tx_busy, ctl_rx_busy,
                   tx_done_q, ~tx_req, overrun_q, ctl_rx_avail};
    end
  end

  // ==========
  // Wishbone read mux and acknowledge
  always @* begin
    case (wb_adr_i)
      `CMQ_REG_CTRL:     rd_d = {31'h0, controller_active};
      `CMQ_REG_STATUS:   rd_d = {24'h0, status_q};
      `CMQ_REG_RESULT:   rd_d = {19'h0, (rxq_cnt_q == 3'h0), 1'b0, rxq_cnt_q,
                                 1'b0, last_hdl_q, rx_qfull_q, hdl_err_q,
                                 cfg_err_q, tx_full_q};
      `CMQ_REG_ACC_CODE: rd_d = accept_code_q;
      `CMQ_REG_ACC_MASK: rd_d = accept_mask_q;
      `CMQ_REG_TIMING:   rd_d = {16'h0000, bit_timing_hi, bit_timing_lo};
      `CMQ_REG_TX_ID:    rd_d = {1'b0, stg_id_q};
      `CMQ_REG_TX_LEN:   rd_d = {28'h0, stg_len_q};
      `CMQ_REG_TX_DLO:   rd_d = stg_dlo_hi_q[31:0];
      `CMQ_REG_TX_DHI:   rd_d = stg_dlo_hi_q[63:32];
      `CMQ_REG_CYC_PER:  rd_d = {16'h0000, cyclic_period_q};
      `CMQ_REG_CYC_HDL:  rd_d = {29'h0, cyc_hdl_q};
      `CMQ_REG_RX_ID:    rd_d = {1'b0, rx_head[`CMQ_FRM_EXT], rx_head[`CMQ_FRM_RTR],
                                 rx_head[`CMQ_FRM_ID_HI:`CMQ_FRM_ID_LO]};
      `CMQ_REG_RX_LEN:   rd_d = {28'h0, rx_head[`CMQ_FRM_LEN_HI:`CMQ_FRM_LEN_LO]};
      `CMQ_REG_RX_DLO:   rd_d = rx_head[31:0];
      `CMQ_REG_RX_DHI:   rd_d = rx_head[63:32];
      `CMQ_REG_STAMP_HI: rd_d = ts_head[63:32];
      `CMQ_REG_STAMP_LO: rd_d = ts_head[31:0];
      default:           rd_d = 32'h0;
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req & ~wb_we_i) begin
        wb_dat_o <= rd_d;
      end
    end
  end

endmodule
